// file: bsal_regs.vh
`ifndef BSAL_REGS_VH
`define BSAL_REGS_VH

// Register byte offsets
`define BSAL_CHIP_CFG_OFS      8'h00
`define BSAL_PIN_CFG_OFS       8'h04
`define BSAL_BUS0_CTL_OFS      8'h08
`define BSAL_BOOT_STAT_OFS     8'h0C

// Strap positions on the address pins
`define BSAL_STRAP_ROLE        19
`define BSAL_STRAP_SELA        18
`define BSAL_STRAP_IPCI        16
`define BSAL_STRAP_SYS_HI      14
`define BSAL_STRAP_SYS_LO      13
`define BSAL_STRAP_ENDIAN      12
`define BSAL_STRAP_PCI_HI      11
`define BSAL_STRAP_PCI_LO      10
`define BSAL_STRAP_SELB        9
`define BSAL_STRAP_BOOT_HI     8
`define BSAL_STRAP_BOOT_LO     6

// Chip configuration register fields
`define BSAL_CC_ROLE_BIT       0
`define BSAL_CC_ENDIAN_BIT     1
`define BSAL_CC_IPCI_BIT       2
`define BSAL_CC_SYS_LSB        4
`define BSAL_CC_PCI_LSB        10
`define BSAL_CC_SWBIT          12

// Pin configuration register fields
`define BSAL_PC_SELA_BIT       0
`define BSAL_PC_SELB_BIT       1

// Channel 0 control register fields
`define BSAL_B0_EN_BIT         0
`define BSAL_B0_RATIO_LSB      1

// Boot status register fields
`define BSAL_BS_CODE_LSB       0
`define BSAL_BS_BUS_BIT        4
`define BSAL_BS_PCI_BIT        5
`define BSAL_BS_NAND_BIT       6
`define BSAL_BS_RSVD_BIT       7
`define BSAL_BS_DIV_LSB        8

// Reset values
`define BSAL_SWBIT_RST         1'b0
`define BSAL_SYS_FIELDS_RST    7'h00
`define BSAL_CG_FIELDS_RST     5'h00

// Boot source codes
`define BSAL_BOOT_PCI          3'h3
`define BSAL_BOOT_NAND         3'h2

`endif

// file: bsal_strap_latch.v
`timescale 1ns/1ns
// Captures a group of strap levels on a one-cycle strobe and holds them.
module bsal_strap_latch #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input  wire             clk,      // system clock
   input  wire             arstN,    // asynchronous clear, active low
   input  wire             syncClr,  // synchronous clear to RST_VAL
   input  wire             capture,  // one-cycle capture strobe
   input  wire [WIDTH-1:0] d,        // strap levels
   output reg  [WIDTH-1:0] q         // held field value
);

   always @(posedge clk or negedge arstN) begin
      if (!arstN) begin
         q <= RST_VAL;
      end else if (syncClr) begin
         q <= RST_VAL;
      end else if (capture) begin
         q <= d;
      end
   end

endmodule

// file: bsal_boot_decode.v
`timescale 1ns/1ns
`include "bsal_regs.vh"
// Registered decode of the three boot source straps.
module bsal_boot_decode (
   input  wire       clk,          // system clock
   input  wire       rstN,         // asynchronous reset, active low
   input  wire [2:0] code,         // latched boot source code
   output reg        bootBus,      // channel 0 device boot
   output reg        bootPci,      // PCI boot
   output reg        bootNand,     // NAND boot
   output reg        bootRsvd,     // reserved code seen
   output reg  [2:0] bootDiv       // channel 0 divisor 1..4, else 0
);

   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         bootBus  <= 1'b0;
         bootPci  <= 1'b0;
         bootNand <= 1'b0;
         bootRsvd <= 1'b0;
         bootDiv  <= 3'h0;
      end else begin
         bootBus  <= code[2];
         bootPci  <= (code == `BSAL_BOOT_PCI);
         bootNand <= (code == `BSAL_BOOT_NAND);
         bootRsvd <= (code[2:1] == 2'h0);
         // HHH..HLL give divide by 1..4
         if (code[2]) begin
            bootDiv <= 3'h4 - {1'b0, code[1:0]};
         end else begin
            bootDiv <= 3'h0;
         end
      end
   end

endmodule

// file: bsal_top.v
`timescale 1ns/1ns
`include "bsal_regs.vh"
// Overview of operation
// - High strap stores one, low stores zero
// - Bit 19 at reset release: PCI role
// - Bit 18 at reset release: shared pins A
// - Bit 16 at clock reset release: internal PCI clock ratio
// - Bits 14:13 at clock reset release: system ratio
// - Bit 12 at reset release: byte order
// - Bits 11:10 at clock reset release: PCI ratio
// - Configuration bit 12 resets to zero
// - Bit 9 at reset release: shared pins B
// - Bits 8:6 at reset release: boot source
module bsal_top (
   input  wire        mclk,            // 25 MHz system clock
   input  wire        rst_b,           // system reset, active low
   input  wire        cgResetN,        // clock generator reset, active low
   input  wire [19:6] addrStrap,       // address pins read as straps
   input  wire        wb_cyc_i,        // Wishbone cycle
   input  wire        wb_stb_i,        // Wishbone strobe
   input  wire        wb_we_i,         // Wishbone write enable
   input  wire [7:0]  wb_adr_i,        // Wishbone byte address
   input  wire [3:0]  wb_sel_i,        // Wishbone byte selects
   input  wire [31:0] wb_dat_i,        // Wishbone write data
   output reg  [31:0] wb_dat_o,        // Wishbone read data
   output reg         wb_ack_o,        // Wishbone acknowledge
   output wire        pciRoleSelect,   // 1 host, 0 satellite
   output wire        sharedPinSelA,   // 1 check bits, 0 general I/O
   output wire        sharedPinSelB,   // 1 audio link, 0 general I/O
   output wire        bigEndian,       // 1 big, 0 little endian
   output wire        intPciClkRatio,  // 1 quarter, 0 half bus clock
   output wire [1:0]  sysClkRatio,     // 0..3 = divide 4,3,2,1
   output wire [1:0]  pciBusClkRatio,  // 0..3 = divide 8,9,10,11
   output wire        ch0BootEnable,   // boot from channel 0 device
   output wire [1:0]  ch0ClkRatio,     // channel 0 clock ratio code
   output wire        bootFromBus,     // decoded channel 0 boot
   output wire        bootFromPci,     // decoded PCI boot
   output wire        bootFromNand,    // decoded NAND boot
   output wire        bootReserved,    // reserved boot code strapped
   output wire [2:0]  ch0ClkDiv,       // channel 0 divisor 1..4, else 0
   output reg  [3:0]  sysClkDiv,       // system clock divisor 1..4
   output reg  [3:0]  pciBusClkDiv,    // PCI bus clock divisor 8..11
   output reg         cfgSwBit12,      // software bit of chip config
   output reg         sysCfgValid,     // system straps captured
   output reg         cgCfgValid       // clock straps captured
);

   // System reset fields: role, selA, endian, selB, boot code
   wire [6:0] sysStrapIn;
   wire [6:0] sysField;
   wire [2:0] bootCode;
   // Clock reset fields: internal PCI, system ratio, PCI ratio
   wire [4:0] cgStrapIn;
   wire [4:0] cgField;

   reg        sysArmed_reg;
   reg        cgPrev_reg;
   reg        cgSeen_reg;
   reg        swBit_reg;
   reg [31:0] rdData_next;
   wire       sysCapture;
   wire       cgCapture;
   wire       wbReq;
   wire       wbWrite;

   assign sysStrapIn = {addrStrap[`BSAL_STRAP_ROLE],
                        addrStrap[`BSAL_STRAP_SELA],
                        addrStrap[`BSAL_STRAP_ENDIAN],
                        addrStrap[`BSAL_STRAP_SELB],
                        addrStrap[`BSAL_STRAP_BOOT_HI:`BSAL_STRAP_BOOT_LO]};
   assign cgStrapIn  = {addrStrap[`BSAL_STRAP_IPCI],
                        addrStrap[`BSAL_STRAP_SYS_HI:`BSAL_STRAP_SYS_LO],
                        addrStrap[`BSAL_STRAP_PCI_HI:`BSAL_STRAP_PCI_LO]};

   // Async reset cannot sample pins, so the capture is the first edge
   // after rst_b releases.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sysArmed_reg <= 1'b0;
      end else begin
         sysArmed_reg <= 1'b1;
      end
   end

   assign sysCapture = !sysArmed_reg;

   // Clock reset is a plain synchronous input; its rising edge captures.
   // These flops ignore rst_b so a system reset alone keeps them.
   always @(posedge mclk) begin
      cgPrev_reg <= cgResetN;
      if (!cgResetN) begin
         cgSeen_reg <= 1'b0;
      end else if (!cgPrev_reg) begin
         cgSeen_reg <= 1'b1;
      end
   end

   assign cgCapture = cgResetN && !cgPrev_reg;

   bsal_strap_latch #(
      .WIDTH   (7),
      .RST_VAL (`BSAL_SYS_FIELDS_RST)
   ) uSysLatch (
      .clk     (mclk),
      .arstN   (rst_b),
      .syncClr (1'b0),
      .capture (sysCapture),
      .d       (sysStrapIn),
      .q       (sysField)
   );

   bsal_strap_latch #(
      .WIDTH   (5),
      .RST_VAL (`BSAL_CG_FIELDS_RST)
   ) uCgLatch (
      .clk     (mclk),
      .arstN   (1'b1),
      .syncClr (!cgResetN),
      .capture (cgCapture),
      .d       (cgStrapIn),
      .q       (cgField)
   );

   assign pciRoleSelect  = sysField[6];
   assign sharedPinSelA  = sysField[5];
   assign bigEndian      = sysField[4];
   assign sharedPinSelB  = sysField[3];
   assign bootCode       = sysField[2:0];
   assign ch0BootEnable  = sysField[2];
   assign ch0ClkRatio    = sysField[1:0];
   assign intPciClkRatio = cgField[4];
   assign sysClkRatio    = cgField[3:2];
   assign pciBusClkRatio = cgField[1:0];

   bsal_boot_decode uBootDec (
      .clk      (mclk),
      .rstN     (rst_b),
      .code     (bootCode),
      .bootBus  (bootFromBus),
      .bootPci  (bootFromPci),
      .bootNand (bootFromNand),
      .bootRsvd (bootReserved),
      .bootDiv  (ch0ClkDiv)
   );

   // Numeric divisors; follow the clock reset domain
   always @(posedge mclk) begin
      if (!cgResetN) begin
         sysClkDiv    <= 4'h0;
         pciBusClkDiv <= 4'h0;
         cgCfgValid   <= 1'b0;
      end else begin
         sysClkDiv    <= 4'h4 - {2'h0, cgField[3:2]};
         pciBusClkDiv <= 4'h8 + {2'h0, cgField[1:0]};
         cgCfgValid   <= cgSeen_reg;
      end
   end

   // Wishbone classic slave: ack one edge after the request
   assign wbReq   = wb_cyc_i && wb_stb_i;
   assign wbWrite = wbReq && wb_we_i && wb_ack_o;

   always @* begin
      rdData_next = 32'h0000_0000;
      if (wb_adr_i == `BSAL_CHIP_CFG_OFS) begin
         rdData_next[`BSAL_CC_ROLE_BIT]   = pciRoleSelect;
         rdData_next[`BSAL_CC_ENDIAN_BIT] = bigEndian;
         rdData_next[`BSAL_CC_IPCI_BIT]   = intPciClkRatio;
         rdData_next[`BSAL_CC_SYS_LSB+1:`BSAL_CC_SYS_LSB] = sysClkRatio;
         rdData_next[`BSAL_CC_PCI_LSB+1:`BSAL_CC_PCI_LSB] = pciBusClkRatio;
         rdData_next[`BSAL_CC_SWBIT]      = swBit_reg;
      end else if (wb_adr_i == `BSAL_PIN_CFG_OFS) begin
         rdData_next[`BSAL_PC_SELA_BIT] = sharedPinSelA;
         rdData_next[`BSAL_PC_SELB_BIT] = sharedPinSelB;
      end else if (wb_adr_i == `BSAL_BUS0_CTL_OFS) begin
         rdData_next[`BSAL_B0_EN_BIT] = ch0BootEnable;
         rdData_next[`BSAL_B0_RATIO_LSB+1:`BSAL_B0_RATIO_LSB] = ch0ClkRatio;
      end else if (wb_adr_i == `BSAL_BOOT_STAT_OFS) begin
         rdData_next[`BSAL_BS_CODE_LSB+2:`BSAL_BS_CODE_LSB] = bootCode;
         rdData_next[`BSAL_BS_BUS_BIT]  = bootFromBus;
         rdData_next[`BSAL_BS_PCI_BIT]  = bootFromPci;
         rdData_next[`BSAL_BS_NAND_BIT] = bootFromNand;
         rdData_next[`BSAL_BS_RSVD_BIT] = bootReserved;
         rdData_next[`BSAL_BS_DIV_LSB+2:`BSAL_BS_DIV_LSB] = ch0ClkDiv;
      end
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h0000_0000;
         swBit_reg   <= `BSAL_SWBIT_RST;
         cfgSwBit12  <= `BSAL_SWBIT_RST;
         sysCfgValid <= 1'b0;
      end else begin
         wb_ack_o    <= wbReq && !wb_ack_o;
         sysCfgValid <= sysArmed_reg;
         if (wbReq && !wb_ack_o) begin
            wb_dat_o <= rdData_next;
         end
         // Strap fields are read only; only the spare bit takes writes
         if (wbWrite && (wb_adr_i == `BSAL_CHIP_CFG_OFS) && wb_sel_i[1]) begin
            swBit_reg  <= wb_dat_i[`BSAL_CC_SWBIT];
            cfgSwBit12 <= wb_dat_i[`BSAL_CC_SWBIT];
         end
      end
   end

endmodule

// file: bsal_strap_board.sv
`timescale 1ns/1ns
// Board straps: pins float high on internal pull-ups unless pulled down
module bsal_strap_board (
   input  wire logic [19:6] pullDown,  // 1 = resistor to ground fitted
   output logic      [19:6] addrStrap  // level seen on the pins
);
   // Test straps 17 and 15 never get a pull-down fitted
   assign addrStrap = ~(pullDown & 14'h35FF);
endmodule

// file: bsal_top_asserts.sv
`timescale 1ns/1ns
module bsal_top_asserts (
   input wire logic        mclk,            // clock
   input wire logic        rst_b,           // system reset
   input wire logic        cgResetN,        // clock reset
   input wire logic [19:6] addrStrap,       // strap pins
   input wire logic        pciRoleSelect,   // role
   input wire logic        sharedPinSelA,   // shared pins A
   input wire logic        sharedPinSelB,   // shared pins B
   input wire logic        bigEndian,       // byte order
   input wire logic        intPciClkRatio,  // internal ratio
   input wire logic [1:0]  sysClkRatio,     // system ratio
   input wire logic [1:0]  pciBusClkRatio,  // bus ratio
   input wire logic        ch0BootEnable,   // boot enable
   input wire logic [1:0]  ch0ClkRatio,     // boot ratio
   input wire logic        bootFromBus,     // bus boot
   input wire logic        bootFromPci,     // pci boot
   input wire logic        bootFromNand,    // nand boot
   input wire logic        bootReserved,    // reserved code
   input wire logic [3:0]  sysClkDiv,       // system divisor
   input wire logic [3:0]  pciBusClkDiv,    // bus divisor
   input wire logic        cfgSwBit12,      // software bit
   input wire logic        sysCfgValid,     // system captured
   input wire logic        cgCfgValid       // clock captured
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire logic [6:0] sysF = {pciRoleSelect, sharedPinSelA, bigEndian,
                            sharedPinSelB, ch0BootEnable, ch0ClkRatio};
   wire logic [4:0] cgF = {intPciClkRatio, sysClkRatio, pciBusClkRatio};
   AST_ROLE: assert property ($rose(sysCfgValid) |->
      pciRoleSelect == $past(addrStrap[19], 2)) else $error("role field");
   AST_SELA: assert property ($rose(sysCfgValid) |->
      sharedPinSelA == $past(addrStrap[18], 2)) else $error("pin select a");
   AST_SYSF: assert property ($rose(sysCfgValid) |->
      {bigEndian, sharedPinSelB} == $past({addrStrap[12], addrStrap[9]}, 2))
      else $error("endian or pin select b");
   AST_BOOT: assert property ($rose(sysCfgValid) |->
      {ch0BootEnable, ch0ClkRatio} == $past(addrStrap[8:6], 2))
      else $error("boot field");
   AST_HOLD: assert property (sysCfgValid && $past(sysCfgValid)
      |-> $stable(sysF)) else $error("system field moved");
   AST_CGCAP: assert property ($rose(cgResetN) |=> cgF ==
      $past({addrStrap[16], addrStrap[14:13], addrStrap[11:10]}))
      else $error("clock field capture");
   AST_CGHOLD: assert property (cgResetN && $past(cgResetN) |=>
      $stable(cgF)) else $error("clock field moved");
   AST_DIV: assert property (cgCfgValid |->
      sysClkDiv == 4'h4 - {2'h0, sysClkRatio} &&
      pciBusClkDiv == 4'h8 + {2'h0, pciBusClkRatio}) else $error("divisor");
   AST_DEC: assert property (sysCfgValid |->
      bootFromPci == (sysF[2:0] == 3'h3) && bootFromNand == (sysF[2:0] ==
      3'h2) && bootReserved == (sysF[2:1] == 2'h0) &&
      bootFromBus == ch0BootEnable) else $error("boot decode");
   AST_SWRST: assert property ($rose(sysCfgValid) |-> !cfgSwBit12)
      else $error("software bit not cleared");
   cover property ($rose(sysCfgValid));
   cover property ($rose(cgCfgValid));
   cover property (sysCfgValid && bootReserved);
endmodule
bind bsal_top bsal_top_asserts chk (.mclk, .rst_b, .cgResetN, .addrStrap,
   .pciRoleSelect, .sharedPinSelA, .sharedPinSelB, .bigEndian,
   .intPciClkRatio, .sysClkRatio, .pciBusClkRatio, .ch0BootEnable,
   .ch0ClkRatio, .bootFromBus, .bootFromPci, .bootFromNand, .bootReserved,
   .sysClkDiv, .pciBusClkDiv, .cfgSwBit12, .sysCfgValid, .cgCfgValid);

// file: tb.sv
`timescale 1ns/1ns
module tb;
   logic mclk = 1'b0, rst_b = 1'b0, cgResetN = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [19:6] pullDown = 14'h0000, addrStrap;
   logic pRole, selA, selB, bigE, iPci, bEn, bBus, bPci, bNand, bRsv, sw;
   logic cgV, sysV;
   logic [1:0] sysR, pciR, ch0R;
   logic [2:0] ch0D;
   logic [3:0] sysD, pciD;
   int nMismatch = 0, cmpCount = 0;
   always #20 mclk = ~mclk;
   bsal_strap_board board (.pullDown(pullDown), .addrStrap(addrStrap));
   bsal_top uut (.mclk(mclk), .rst_b(rst_b), .cgResetN(cgResetN),
      .addrStrap(addrStrap), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .pciRoleSelect(pRole), .sharedPinSelA(selA), .sharedPinSelB(selB),
      .bigEndian(bigE), .intPciClkRatio(iPci), .sysClkRatio(sysR),
      .pciBusClkRatio(pciR), .ch0BootEnable(bEn), .ch0ClkRatio(ch0R),
      .bootFromBus(bBus), .bootFromPci(bPci), .bootFromNand(bNand),
      .bootReserved(bRsv), .ch0ClkDiv(ch0D), .sysClkDiv(sysD),
      .pciBusClkDiv(pciD), .cfgSwBit12(sw), .sysCfgValid(sysV),
      .cgCfgValid(cgV));
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      cmpCount++;
      if (seen !== exp) begin
         nMismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Holds the request until ack is sampled, then drops it for a cycle
   task automatic wb(input logic we, input logic [7:0] a, input int d);
      int i = 0;
      logic ok;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      ok = (wb_ack_o === 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
      if (!ok) begin
         nMismatch++;
         give_verdict();
      end
   endtask
   initial begin
      int k, c, bus, div, cc, ex;
      logic [19:6] s1, s2;
      void'($urandom(32'hCF0A));
      repeat (5) @(posedge mclk);
      for (k = 0; k < 16; k++) begin
         s1 = 14'($urandom) | 14'h0A00;
         s1[8:6] = 3'(k);
         s2 = 14'($urandom) | 14'h0A00;
         pullDown <= ~s1;
         rst_b <= 1'b0;
         cgResetN <= 1'b0;
         repeat (2) @(posedge mclk);
         rst_b <= 1'b1;
         cgResetN <= 1'b1;
         repeat (4) @(posedge mclk);
         pullDown <= ~s2;
         cgResetN <= 1'b0;
         repeat (2) @(posedge mclk);
         cgResetN <= 1'b1;
         repeat (4) @(posedge mclk);
         // Pins wander after capture; nothing may follow them
         pullDown <= 14'($urandom);
         @(posedge mclk);
         c = s1[8:6];
         bus = c / 4;
         div = bus ? 8 - c : 0;
         check("role", pRole, s1[19]);
         check("selA", selA, s1[18]);
         check("endian", bigE, s1[12]);
         check("selB", selB, s1[9]);
         check("bootf", {bEn, ch0R}, s1[8:6]);
         check("ipci", iPci, s2[16]);
         check("sysr", sysR, s2[14:13]);
         check("pcir", pciR, s2[11:10]);
         check("valid", {sysV, cgV}, 2'h3);
         ex = (4 - s2[14:13]) * 16 + 8 + s2[11:10];
         check("div", {sysD, pciD}, ex);
         ex = {bus[0], c == 3, c == 2, c < 2, div[2:0]};
         check("boot", {bBus, bPci, bNand, bRsv, ch0D}, ex);
         wb(1'b0, 8'h0C, 0);
         ex = c + (c == 3) * 32 + (c == 2) * 64 + (c < 2) * 128 + bus * 16
            + div * 256;
         check("bstat", rd, ex);
         cc = s1[19] + s1[12] * 2 + s2[16] * 4 + s2[14:13] * 16
            + s2[11:10] * 1024;
         wb(1'b0, 8'h00, 0);
         check("chip_configuration_register", rd, cc);
         check("swrst", sw, 1'b0);
         // Byte lane 1 off: the spare bit must not take the write
         wb_sel_i <= 4'hD;
         wb(1'b1, 8'h00, -1);
         wb_sel_i <= 4'hF;
         wb(1'b0, 8'h00, 0);
         check("ccfgsel", rd, cc);
         wb(1'b1, 8'h00, -1);
         wb(1'b0, 8'h00, 0);
         check("ccfgw", rd, cc + 4096);
         check("sw", sw, 1'b1);
         wb(1'b0, 8'h04, 0);
         check("pin_configuration_register", rd, s1[18] + s1[9] * 2);
         wb(1'b1, 8'h08, 0);
         wb(1'b0, 8'h08, 0);
         check("ch0", rd, s1[8] + s1[7:6] * 2);
         wb(1'b1, 8'h10, -1);
         wb(1'b0, 8'h10, 0);
         check("unmapped", rd, 0);
      end
      give_verdict();
   end
endmodule
